// >>> core/chadc_pkg.sv
package chadc_pkg;
    // register byte addresses; 16-bit results are low byte first
    localparam logic [7:0] ADDR_CONTROL = 8'h26;
    localparam logic [7:0] ADDR_CHAN_OFF = 8'h27;
    localparam logic [7:0] ADDR_IBUS_LO = 8'h28;
    localparam logic [7:0] ADDR_IBUS_HI = 8'h29;
    localparam logic [7:0] ADDR_IBAT_LO = 8'h2a;
    localparam logic [7:0] ADDR_IBAT_HI = 8'h2b;

    // control register fields
    localparam int CTL_EN_BIT = 7;
    localparam int CTL_RATE_BIT = 6;
    localparam int CTL_RES_LSB = 4;
    localparam int CTL_AVG_BIT = 3;
    localparam int CTL_SEED_BIT = 2;
    localparam logic [7:0] CTL_WR_MASK = 8'hfc;
    localparam logic [7:0] CTL_RESET = 8'h30;
    localparam logic [7:0] CHAN_OFF_RESET = 8'h00;

    // channel indices in scan order; disable bit is 7 - index
    localparam logic [2:0] CH_IBUS = 3'h0;
    localparam logic [2:0] CH_IBAT = 3'h1;
    localparam logic [2:0] CH_LAST = 3'h7;

    // result fields: input current 15 bits at 15:1, battery 14 bits at 15:2
    localparam int IBUS_SHIFT = 1;
    localparam int IBAT_SHIFT = 2;
    localparam logic signed [15:0] IBUS_MIN = -16'sh07d0;
    localparam logic signed [15:0] IBUS_MAX = 16'sh07d0;
    localparam logic signed [15:0] IBAT_MIN = -16'sh0753;
    localparam logic signed [15:0] IBAT_MAX = 16'sh03e8;
    localparam logic [13:0] IBAT_ABORT = 14'h2000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SCAN = 2'b01,
        ST_WAIT = 2'b10
    } chadc_state_e;

    // request to the analog converter
    typedef struct packed {
        logic start;
        logic [2:0] chan;
        logic [1:0] res;
    } chadc_req_s;
endpackage

// >>> core/chadc_core.sv
`timescale 1ns/100ps
// Functional notes
// - control bit 7 enables conversions; reset value is disabled.
// - results reset to zero and hold the last value; disabling never clears.
// - control bit 6: 0 continuous conversion, 1 one-shot pass.
// - bits 5:4 pick 12, 11, 10 or 9 bit resolution; reset code 3.
// - bit 3 selects single result or running average.
// - bit 2: average starts from existing register value or fresh conversion.
// - disable register bits 7..0 skip channels; all enabled after reset.
// - input current is two's complement in bits 15:1, positive bus to mid node.
// - input current step 2 mA, clamped to plus or minus 4000 mA.
// - battery current is two's complement in bits 15:2, positive when charging.
// - battery current result is zero while charge_allow is low.
// - battery current step 4 mA, clamped to -7500..4000 mA.
// - battery current is non-negative in forward mode, non-positive on battery.
// - polarity flip during battery conversion aborts and loads code 0x8000.
// - one-shot completion pulses the done event unless masked.
module chadc_core
    import chadc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // register port from the serial interface
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // analog converter
    output chadc_req_s conv_req_out,
    input wire logic conv_done_in,
    input wire logic signed [15:0] conv_sample_in,
    // charger state
    input wire logic charge_allow_in,
    input wire logic fwd_mode_in,
    input wire logic bat_charging_in,
    input wire logic done_mask_in,
    // events
    output logic done_event_out
);
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] chan_off_q;
    logic [14:0] ibus_field_q, ibus_field_d;
    logic [13:0] ibat_field_q, ibat_field_d;
    logic [1:0] seeded_q, seeded_d;
    logic pol_q;
    logic [2:0] ptr_q, ptr_d;
    chadc_state_e state_q, state_d;
    logic start_d;
    logic done_d, done_q;

    wire conv_en = ctrl_q[CTL_EN_BIT];
    wire one_shot = ctrl_q[CTL_RATE_BIT];
    wire avg_on = ctrl_q[CTL_AVG_BIT];
    wire seed_fresh = ctrl_q[CTL_SEED_BIT];
    wire [1:0] res_code = ctrl_q[CTL_RES_LSB +: 2];

    // register decode and read data
    wire wr_ctrl = reg_wr_in && (reg_addr_in == ADDR_CONTROL);
    wire wr_off = reg_wr_in && (reg_addr_in == ADDR_CHAN_OFF);
    wire [15:0] ibus_reg = {ibus_field_q, 1'b0};
    wire [15:0] ibat_reg = {ibat_field_q, 2'b00};
    logic [7:0] rd_mux;
    always_comb begin
        if (reg_addr_in == ADDR_CONTROL) begin
            rd_mux = ctrl_q & CTL_WR_MASK;
        end else if (reg_addr_in == ADDR_CHAN_OFF) begin
            rd_mux = chan_off_q;
        end else if (reg_addr_in == ADDR_IBUS_LO) begin
            rd_mux = ibus_reg[7:0];
        end else if (reg_addr_in == ADDR_IBUS_HI) begin
            rd_mux = ibus_reg[15:8];
        end else if (reg_addr_in == ADDR_IBAT_LO) begin
            rd_mux = ibat_reg[7:0];
        end else if (reg_addr_in == ADDR_IBAT_HI) begin
            rd_mux = ibat_reg[15:8];
        end else begin
            rd_mux = 8'h00;
        end
    end

    // channel scan
    wire chan_enabled = !chan_off_q[3'h7 - ptr_q];
    wire at_last = (ptr_q == CH_LAST);
    wire conv_fin = (state_q == ST_WAIT) && conv_done_in;

    always_comb begin
        state_d = state_q;
        ptr_d = ptr_q;
        start_d = 1'b0;
        done_d = 1'b0;
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = reg_wdata_in & CTL_WR_MASK;
        end
        case (state_q)
            ST_IDLE: begin
                ptr_d = 3'h0;
                if (conv_en) begin
                    state_d = ST_SCAN;
                end
            end
            ST_SCAN: begin
                if (!conv_en) begin
                    state_d = ST_IDLE;
                end else if (chan_enabled) begin
                    start_d = 1'b1;
                    state_d = ST_WAIT;
                end else if (at_last && one_shot) begin
                    done_d = 1'b1;
                    state_d = ST_IDLE;
                    if (!wr_ctrl) begin
                        ctrl_d[CTL_EN_BIT] = 1'b0;
                    end
                end else begin
                    ptr_d = ptr_q + 3'h1;
                end
            end
            ST_WAIT: begin
                if (!conv_en) begin
                    // abandon the channel; only a sample arriving in this same cycle still updates its result
                    state_d = ST_IDLE;
                end else if (conv_done_in) begin
                    if (at_last && one_shot) begin
                        done_d = 1'b1;
                        state_d = ST_IDLE;
                        if (!wr_ctrl) begin
                            ctrl_d[CTL_EN_BIT] = 1'b0;
                        end
                    end else begin
                        ptr_d = ptr_q + 3'h1;
                        state_d = ST_SCAN;
                    end
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // result arithmetic on field codes
    function automatic logic signed [15:0] avg2(input logic signed [15:0] a,
                                                input logic signed [15:0] b);
        logic signed [16:0] s;
        s = {a[15], a} + {b[15], b};
        return s[16:1];
    endfunction

    wire signed [15:0] ibus_div = conv_sample_in >>> IBUS_SHIFT;
    wire signed [15:0] ibat_div = conv_sample_in >>> IBAT_SHIFT;
    wire signed [15:0] ibus_clip = (ibus_div < IBUS_MIN) ? IBUS_MIN :
        (ibus_div > IBUS_MAX) ? IBUS_MAX : ibus_div;
    wire signed [15:0] ibat_clip = (ibat_div < IBAT_MIN) ? IBAT_MIN :
        (ibat_div > IBAT_MAX) ? IBAT_MAX : ibat_div;
    // forward mode cannot discharge, battery-only mode cannot charge
    wire signed [15:0] ibat_pol = fwd_mode_in ?
        (ibat_clip[15] ? 16'sh0000 : ibat_clip) :
        (ibat_clip[15] ? ibat_clip : 16'sh0000);
    wire signed [15:0] ibus_old = {ibus_field_q[14], ibus_field_q};
    wire signed [15:0] ibat_old = {{2{ibat_field_q[13]}}, ibat_field_q};
    // seed from register unless a fresh conversion was asked for
    wire [1:0] use_avg = {2{avg_on}} & (seeded_q | {2{!seed_fresh}});
    wire signed [15:0] ibus_new = use_avg[0] ? avg2(ibus_old, ibus_clip) : ibus_clip;
    wire signed [15:0] ibat_new = use_avg[1] ? avg2(ibat_old, ibat_pol) : ibat_pol;
    wire pol_flip = (pol_q != bat_charging_in);

    always_comb begin
        ibus_field_d = ibus_field_q;
        ibat_field_d = ibat_field_q;
        seeded_d = avg_on ? seeded_q : 2'b00;
        if (conv_fin && (ptr_q == CH_IBUS)) begin
            ibus_field_d = ibus_new[14:0];
            seeded_d[0] = avg_on;
        end
        if (!charge_allow_in) begin
            ibat_field_d = 14'h0000;
            seeded_d[1] = 1'b0;
        end else if (conv_fin && (ptr_q == CH_IBAT)) begin
            if (pol_flip) begin
                ibat_field_d = IBAT_ABORT;
            end else begin
                ibat_field_d = ibat_new[13:0];
                seeded_d[1] = avg_on;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ctrl_q <= CTL_RESET;
            chan_off_q <= CHAN_OFF_RESET;
            ibus_field_q <= '0;
            ibat_field_q <= '0;
            seeded_q <= 2'b00;
            state_q <= ST_IDLE;
            ptr_q <= 3'h0;
            pol_q <= 1'b0;
            done_q <= 1'b0;
            reg_rdata_out <= 8'h00;
            conv_req_out <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            if (wr_off) begin
                chan_off_q <= reg_wdata_in;
            end
            ibus_field_q <= ibus_field_d;
            ibat_field_q <= ibat_field_d;
            seeded_q <= seeded_d;
            state_q <= state_d;
            ptr_q <= ptr_d;
            // polarity is captured as the conversion starts
            if (start_d) begin
                pol_q <= bat_charging_in;
            end
            done_q <= done_d && !done_mask_in;
            if (reg_rd_in) begin
                reg_rdata_out <= rd_mux;
            end
            conv_req_out.start <= start_d;
            conv_req_out.chan <= ptr_q;
            conv_req_out.res <= res_code;
        end
    end

    assign done_event_out = done_q;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);

    a_chg_off_zero: assert property (!charge_allow_in |=> ibat_field_q == 14'h0000)
        else $error("battery result not zero while charging disallowed");
    a_abort_code_load: assert property (conv_fin && ptr_q == CH_IBAT && pol_flip
        && charge_allow_in |=> ibat_field_q == 14'h2000)
        else $error("polarity flip did not load abort code");
    a_ibus_range_ok: assert property ($signed(ibus_field_q) >= -15'sd2000
        && $signed(ibus_field_q) <= 15'sd2000)
        else $error("input current field out of range");
    a_ibat_range_ok: assert property (ibat_field_q == 14'h2000
        || ($signed(ibat_field_q) >= -14'sd1875 && $signed(ibat_field_q) <= 14'sd1000))
        else $error("battery current field out of range");
    a_fwd_sign_ok: assert property (conv_fin && ptr_q == CH_IBAT && !pol_flip
        && charge_allow_in && fwd_mode_in |=> !ibat_field_q[13])
        else $error("negative battery current in forward mode");
    a_skip_disabled: assert property (start_d |-> !chan_off_q[3'h7 - ptr_q]
        ##1 conv_req_out.start)
        else $error("disabled channel was started");
    a_off_no_start: assert property (!conv_en |-> !start_d)
        else $error("conversion started while disabled");
    a_oneshot_end: assert property (done_d |=> !conv_en && state_q == ST_IDLE
        ##1 state_q == ST_IDLE)
        else $error("one-shot pass did not clear enable and idle");
    a_done_mask_gate: assert property (done_d && !done_mask_in |=> done_event_out
        ##1 !done_event_out)
        else $error("done event missing or not one cycle");
    a_hold_idle_res: assert property (state_q != ST_WAIT |=> $stable(ibus_field_q))
        else $error("input current result changed without a conversion");
endmodule

// >>> test/chadc_core_tb.sv
`timescale 1ns/100ps
module chadc_core_tb;
    import chadc_pkg::*;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [7:0] reg_addr_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_rd_in = 1'b0;
    logic [7:0] reg_rdata_out;
    chadc_req_s conv_req_out;
    logic conv_done_in = 1'b0;
    logic signed [15:0] conv_sample_in = 16'sh0000;
    logic charge_allow_in = 1'b1;
    logic fwd_mode_in = 1'b1;
    logic bat_charging_in = 1'b1;
    logic done_mask_in = 1'b0;
    logic done_event_out;
    int error_cnt = 0;
    int check_count = 0;
    int cycles = 0;
    logic [15:0] rv;
    logic hit;
    logic pend = 1'b0;
    logic [2:0] pch = 3'h0;
    logic [1:0] pres = 2'h0;
    // alternating input current / battery current samples and expected registers
    logic signed [15:0] smp [12] = '{16'sd100, 16'sd400, 16'sd5000, 16'sd9000, -16'sd9000,
        -16'sd400, -16'sd4, -16'sd30000, 16'sd1000, 16'sd400, 16'sd1000, 16'sd400};
    logic [15:0] expv [12] = '{16'h0064, 16'h0190, 16'h0fa0, 16'h0fa0, 16'hf060, 16'h0000,
        16'hfffc, 16'he2b4, 16'h03e8, 16'h0000, 16'h03e8, 16'h8000};

    chadc_core dut (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .reg_addr_in(reg_addr_in),
        .reg_wr_in(reg_wr_in),
        .reg_wdata_in(reg_wdata_in),
        .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out),
        .conv_req_out(conv_req_out),
        .conv_done_in(conv_done_in),
        .conv_sample_in(conv_sample_in),
        .charge_allow_in(charge_allow_in),
        .fwd_mode_in(fwd_mode_in),
        .bat_charging_in(bat_charging_in),
        .done_mask_in(done_mask_in),
        .done_event_out(done_event_out)
    );

    always #4 clk_in = ~clk_in;

    // start is a one-cycle pulse; latch it so a register read in between cannot miss it
    always @(negedge clk_in) begin
        if (conv_req_out.start === 1'b1) begin
            pend = 1'b1;
            pch = conv_req_out.chan;
            pres = conv_req_out.res;
        end
    end

    task automatic summarize();
        if (error_cnt == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // hang guard: the whole sequence needs well under 3000 cycles
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic chk(input logic [15:0] seen_v, input logic [15:0] exp_v);
        check_count++;
        if (seen_v !== exp_v) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen_v, exp_v);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        @(negedge clk_in);
        reg_wr_in = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(negedge clk_in);
        reg_addr_in = a;
        reg_rd_in = 1'b1;
        @(negedge clk_in);
        reg_rd_in = 1'b0;
        v = {8'h00, reg_rdata_out};
    endtask

    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        logic [15:0] lo;
        logic [15:0] hi;
        rd(a, lo);
        rd(a + 8'h01, hi);
        v = {hi[7:0], lo[7:0]};
    endtask

    // stop first so a pending request is dropped before the channel set changes
    task automatic cfg(input logic [7:0] ctl, input logic [7:0] off);
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_CHAN_OFF, off);
        pend = 1'b0;
        wr(ADDR_CONTROL, ctl);
    endtask

    // answer one converter request; flip reverses polarity while converting
    task automatic serve(input logic [2:0] ch, input logic [1:0] res,
                         input logic signed [15:0] s, input logic flip);
        int n;
        n = 0;
        @(negedge clk_in);
        while (pend !== 1'b1 && n < 60) begin
            @(negedge clk_in);
            n++;
        end
        chk({pend, 12'h000, pch}, {1'b1, 12'h000, ch});
        chk({14'h0000, pres}, {14'h0000, res});
        pend = 1'b0;
        if (flip)
            bat_charging_in = ~bat_charging_in;
        repeat (2) @(negedge clk_in);
        conv_done_in = 1'b1;
        conv_sample_in = s;
        @(negedge clk_in);
        conv_done_in = 1'b0;
        conv_sample_in = ~s;
    endtask

    task automatic watch(output logic got);
        got = 1'b0;
        repeat (20) begin
            @(negedge clk_in);
            if (done_event_out === 1'b1)
                got = 1'b1;
        end
    endtask

    initial begin
        repeat (6) @(posedge clk_in);
        @(negedge clk_in);
        srst_in = 1'b0;
        rd(ADDR_CONTROL, rv);
        chk(rv, 16'h0030);
        rd(ADDR_CHAN_OFF, rv);
        chk(rv, 16'h0000);
        rd16(ADDR_IBUS_LO, rv);
        chk(rv, 16'h0000);
        rd16(ADDR_IBAT_LO, rv);
        chk(rv, 16'h0000);
        wr(8'h20, 8'hff);
        rd(8'h20, rv);
        chk(rv, 16'h0000);
        wr(ADDR_CONTROL, 8'h7f);
        rd(ADDR_CONTROL, rv);
        chk(rv, 16'h007c);
        cfg(8'h80, 8'h3f);
        for (int i = 0; i < 12; i++) begin
            fwd_mode_in = (i != 7 && i != 9);
            // polarity is captured when the next start fires, during the previous read
            bat_charging_in = (i != 6 && i != 7);
            serve((i % 2 == 0) ? CH_IBUS : CH_IBAT, 2'h0, smp[i], i == 11);
            rd16((i % 2 == 0) ? ADDR_IBUS_LO : ADDR_IBAT_LO, rv);
            chk(rv, expv[i]);
        end
        charge_allow_in = 1'b0;
        repeat (3) @(negedge clk_in);
        rd16(ADDR_IBAT_LO, rv);
        chk(rv, 16'h0000);
        charge_allow_in = 1'b1;
        wr(ADDR_CONTROL, 8'h00);
        rd16(ADDR_IBUS_LO, rv);
        chk(rv, 16'h03e8);
        for (int r = 0; r < 4; r++) begin
            cfg({2'b10, 2'(r), 4'h0}, 8'h7f);
            serve(CH_IBUS, 2'(r), 16'sd200, 1'b0);
        end
        cfg(8'h88, 8'h7f);
        serve(CH_IBUS, 2'h0, 16'sd600, 1'b0);
        rd16(ADDR_IBUS_LO, rv);
        chk(rv, 16'h0190);
        cfg(8'h8c, 8'h7f);
        serve(CH_IBUS, 2'h0, 16'sd600, 1'b0);
        rd16(ADDR_IBUS_LO, rv);
        chk(rv, 16'h0258);
        serve(CH_IBUS, 2'h0, 16'sd200, 1'b0);
        rd16(ADDR_IBUS_LO, rv);
        chk(rv, 16'h0190);
        cfg(8'hc0, 8'h7f);
        serve(CH_IBUS, 2'h0, 16'sd100, 1'b0);
        watch(hit);
        chk({15'h0000, hit}, 16'h0001);
        rd(ADDR_CONTROL, rv);
        chk(rv, 16'h0040);
        done_mask_in = 1'b1;
        cfg(8'hc0, 8'h7f);
        serve(CH_IBUS, 2'h0, 16'sd100, 1'b0);
        watch(hit);
        chk({15'h0000, hit}, 16'h0000);
        rd16(ADDR_IBUS_LO, rv);
        chk(rv, 16'h0064);
        summarize();
    end
endmodule
